/* include/bsid_defs.svh */
// bsid_defs.svh: constants of the boundary-scan instruction decode block
// assumes inclusion by bare name from the package and the design files
`ifndef BSID_DEFS_SVH
`define BSID_DEFS_SVH
`define BSID_IR_W        4
`define BSID_OP_EXTEST   4'h0
`define BSID_OP_SAMPLE   4'h1
`define BSID_OP_IDLOAD   4'h2
`define BSID_OP_FLOAT    4'h3
`define BSID_OP_CLAMP    4'h8
`define BSID_OP_CAPTURE  4'hd
`define BSID_OP_BYPASS   4'hf
`define BSID_ID_W        32
`define BSID_REV_LSB     28
`define BSID_PART_LSB    12
`define BSID_VEND_LSB    1
`define BSID_POR_CYCLES  4'h8
`endif

/* include/bsid_pkg.sv */
// bsid_pkg.sv: types of the boundary-scan instruction decode block
// assumes bsid_defs.svh is on the include path
`include "bsid_defs.svh"
package bsid_pkg;
   // test-access states, one-hot
   typedef enum logic [15:0] {
      BSID_RESET    = 16'h0001,
      BSID_IDLE     = 16'h0002,
      BSID_SEL_DR   = 16'h0004,
      BSID_CAP_DR   = 16'h0008,
      BSID_SHIFT_DR = 16'h0010,
      BSID_EXIT1_DR = 16'h0020,
      BSID_PAUSE_DR = 16'h0040,
      BSID_EXIT2_DR = 16'h0080,
      BSID_UPD_DR   = 16'h0100,
      BSID_SEL_IR   = 16'h0200,
      BSID_CAP_IR   = 16'h0400,
      BSID_SHIFT_IR = 16'h0800,
      BSID_EXIT1_IR = 16'h1000,
      BSID_PAUSE_IR = 16'h2000,
      BSID_EXIT2_IR = 16'h4000,
      BSID_UPD_IR   = 16'h8000
   } bsid_state_t;
   // scan path selection
   typedef enum logic [1:0] {
      BSID_PATH_CHAIN = 2'h0,
      BSID_PATH_PASS  = 2'h1,
      BSID_PATH_IDENT = 2'h2
   } bsid_path_t;
endpackage

/* logic/bsid_sync.sv */
// bsid_sync.sv: two-flop synchroniser for a bundle of pin levels
// assumes the pins are asynchronous to clock_i
`timescale 1ns/1ps
module bsid_sync #(
   parameter int W = 1
) (
   input  wire logic         clock_i,  // block clock
   input  wire logic         rst_i,    // async reset, high
   input  wire logic [W-1:0] async_i,  // pin levels
   output logic      [W-1:0] sync_o    // synchronised levels
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_sync;
   // next values: first stage feeds only the second
   always_comb begin
      next_meta = async_i;
      next_sync = meta;
   end
   // register both stages
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         meta   <= '0;
         sync_o <= '0;
      end else begin
         meta   <= next_meta;
         sync_o <= next_sync;
      end
   end
endmodule

/* logic/bsid_top.sv */
// bsid_top.sv: test-access port with instruction decode and scan registers
// assumes test pins arrive asynchronously and are sampled by clock_i
`timescale 1ns/1ps
`include "bsid_defs.svh"
// Overview of operation
// R1 - code 0000: drive outputs from cells
// R2 - code 0001: chain captures pins for shifting
// R3 - code 0001: shifted data preloads the cells
// R4 - code 0010: load and shift identification word
// R5 - code 0011: float outputs, single bit path
// R6 - code 1000: drive from cells, single bit path
// R7 - capture-instruction state loads code 1101
// R8 - code 1111: single bit scan path
// R9 - controller avoids reserved instruction codes
// R10 - cells cover all functional inputs and outputs
// R11 - identification word: revision, part, vendor, one
// R12 - self reset at power-up, reset pin optional
// R13 - standard sixteen-state sequence on rising clock
// R14 - output on falling edge, only while shifting
module bsid_top
   import bsid_pkg::*;
#(
   parameter int          N_IN    = 8,      // functional inputs
   parameter int          N_OUT   = 8,      // functional outputs
   parameter logic [3:0]  REV_ID  = 4'h1,   // arbitrary value
   parameter logic [15:0] PART_ID = 16'h0101, // arbitrary value
   parameter logic [10:0] VEND_ID = 11'h011 // arbitrary value
) (
   input  wire logic             clock_i,    // 40 MHz block clock
   input  wire logic             rst_i,      // async reset, high
   input  wire logic             tck_i,      // test clock pin
   input  wire logic             tms_i,      // mode select pin
   input  wire logic             tdi_i,      // test data in pin
   input  wire logic             trst_n_i,   // optional test reset, low
   input  wire logic [N_IN-1:0]  core_in_i,  // functional input pins
   input  wire logic [N_OUT-1:0] core_out_i, // core's output values
   output logic                  tdo_o,      // test data out
   output logic                  tdo_oe_o,   // test data out enable
   output logic      [N_OUT-1:0] pin_out_o,  // values to output pins
   output logic                  pin_oe_o,   // output drivers enabled
   output logic      [N_IN-1:0]  core_ins_o  // inputs seen by the core
);
   // boundary chain: inputs in the low bits, so input bit 0 leaves first
   localparam int NB = N_IN + N_OUT;          // see R10
   // identification word; bit 0 fixed high marks the register present
   localparam logic [31:0] ID_WORD = {REV_ID, PART_ID, VEND_ID, 1'b1};
   // power-up hold, so the port needs no reset pin
   localparam logic [3:0] POR_N = `BSID_POR_CYCLES;

   // synchronised pins, test clock edges, tap state and scan registers
   logic [3:0]  pins;
   logic        tck_s, tms_s, tdi_s, trst_n_s;
   logic        tck_d, next_tck_d;
   logic        rise, fall;
   bsid_state_t st, next_st;
   logic [3:0]  ir_sh, next_ir_sh, ir, next_ir;
   logic [NB-1:0] chain, next_chain, cells, next_cells;
   logic [31:0] idr, next_idr;
   logic        pass, next_pass;
   logic        tdo_r, next_tdo_r, tdo_en, next_tdo_en;
   logic [3:0]  por, next_por;
   // controls decoded from the current instruction
   bsid_path_t  path;
   logic        drive_cells, floating, sample_cells;

   // pins into the clock domain; test clock edges are seen three clocks late,
   // so the link must run at eight block clocks a period or slower
   bsid_sync #(.W(4)) u_sync (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .async_i ({tck_i, tms_i, tdi_i, trst_n_i}),
      .sync_o  (pins)
   );
   assign {tck_s, tms_s, tdi_s, trst_n_s} = pins;
   // edges of the synchronised test clock; it idles low, so no edge after reset
   assign rise = tck_s & ~tck_d;
   assign fall = ~tck_s & tck_d;

   // tap state sequence on rising test clock
   function automatic bsid_state_t step(input bsid_state_t s, input logic m);
      case (s)
         BSID_RESET:    step = m ? BSID_RESET   : BSID_IDLE;
         BSID_IDLE:     step = m ? BSID_SEL_DR  : BSID_IDLE;
         BSID_SEL_DR:   step = m ? BSID_SEL_IR  : BSID_CAP_DR;
         BSID_CAP_DR:   step = m ? BSID_EXIT1_DR : BSID_SHIFT_DR;
         BSID_SHIFT_DR: step = m ? BSID_EXIT1_DR : BSID_SHIFT_DR;
         BSID_EXIT1_DR: step = m ? BSID_UPD_DR  : BSID_PAUSE_DR;
         BSID_PAUSE_DR: step = m ? BSID_EXIT2_DR : BSID_PAUSE_DR;
         BSID_EXIT2_DR: step = m ? BSID_UPD_DR  : BSID_SHIFT_DR;
         BSID_UPD_DR:   step = m ? BSID_SEL_DR  : BSID_IDLE;
         BSID_SEL_IR:   step = m ? BSID_RESET   : BSID_CAP_IR;
         BSID_CAP_IR:   step = m ? BSID_EXIT1_IR : BSID_SHIFT_IR;
         BSID_SHIFT_IR: step = m ? BSID_EXIT1_IR : BSID_SHIFT_IR;
         BSID_EXIT1_IR: step = m ? BSID_UPD_IR  : BSID_PAUSE_IR;
         BSID_PAUSE_IR: step = m ? BSID_EXIT2_IR : BSID_PAUSE_IR;
         BSID_EXIT2_IR: step = m ? BSID_UPD_IR  : BSID_SHIFT_IR;
         BSID_UPD_IR:   step = m ? BSID_SEL_DR  : BSID_IDLE;
         // an illegal state code falls back to reset
         default:       step = BSID_RESET;
      endcase
   endfunction

   // instruction decode; reserved codes fall to the single bit path
   always_comb begin
      path         = BSID_PATH_PASS;
      drive_cells  = 1'b0;
      floating     = 1'b0;
      sample_cells = 1'b0;
      // reserved codes keep the defaults: single bit path, pins from the core
      case (ir)
         `BSID_OP_EXTEST: begin
            path        = BSID_PATH_CHAIN;          // see R1
            drive_cells = 1'b1;
         end
         `BSID_OP_SAMPLE: begin
            path         = BSID_PATH_CHAIN;         // see R2
            sample_cells = 1'b1;
         end
         `BSID_OP_IDLOAD: path = BSID_PATH_IDENT;  // see R4
         `BSID_OP_FLOAT:  floating = 1'b1;         // see R5
         `BSID_OP_CLAMP:  drive_cells = 1'b1;      // see R6
         `BSID_OP_BYPASS: path = BSID_PATH_PASS;   // see R8
         default:         path = BSID_PATH_PASS;   // see R9
      endcase
   end

   // next state of tap, registers and output
   always_comb begin
      next_tck_d  = tck_s;
      next_st     = st;
      next_ir_sh  = ir_sh;
      next_ir     = ir;
      next_chain  = chain;
      next_cells  = cells;
      next_idr    = idr;
      next_pass   = pass;
      next_tdo_r  = tdo_r;
      next_tdo_en = tdo_en;
      next_por    = (por != 4'h0) ? por - 4'h1 : por;
      if (por != 4'h0 || !trst_n_s) begin
         // a reset in mid-scan releases data out at once
         next_st     = BSID_RESET;                  // see R12
         next_ir     = `BSID_OP_BYPASS;
         next_tdo_en = 1'b0;                        // see R14
      end else if (rise) begin
         next_st = step(st, tms_s);                 // see R13
         // register actions belong to the state this rise leaves
         case (st)
            BSID_RESET: next_ir = `BSID_OP_BYPASS;
            BSID_CAP_IR: next_ir_sh = `BSID_OP_CAPTURE; // see R7
            BSID_SHIFT_IR: next_ir_sh = {tdi_s, ir_sh[3:1]};
            BSID_UPD_IR: next_ir = ir_sh;           // see R14
            BSID_CAP_DR: begin
               // the single bit stage captures 0
               next_pass = 1'b0;
               if (path == BSID_PATH_IDENT)
                  next_idr = ID_WORD;               // see R4 R11
               if (path == BSID_PATH_CHAIN)
                  next_chain = {core_out_i, core_in_i}; // see R2 R10
            end
            BSID_SHIFT_DR: begin
               next_pass = tdi_s;
               next_idr  = {tdi_s, idr[31:1]};
               if (path == BSID_PATH_CHAIN)
                  next_chain = {tdi_s, chain[NB-1:1]};
            end
            BSID_UPD_DR: begin
               // cells take the chain under sample (preload) and under extest only
               if (sample_cells || (drive_cells && path == BSID_PATH_CHAIN))
                  next_cells = chain;               // see R3
            end
            default: next_ir = ir;
         endcase
      end else if (fall) begin
         // data out changes on falling edge while shifting
         next_tdo_en = (st == BSID_SHIFT_DR) || (st == BSID_SHIFT_IR); // see R14
         if (st == BSID_SHIFT_IR)
            next_tdo_r = ir_sh[0];
         else if (path == BSID_PATH_CHAIN)
            next_tdo_r = chain[0];
         else if (path == BSID_PATH_IDENT)
            next_tdo_r = idr[0];
         else
            next_tdo_r = pass;
      end
   end

   // register state
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         tck_d  <= 1'b0;
         st     <= BSID_RESET;
         ir_sh  <= 4'h0;
         ir     <= `BSID_OP_BYPASS;
         chain  <= '0;
         cells  <= '0;
         idr    <= '0;
         pass   <= 1'b0;
         tdo_r  <= 1'b0;
         tdo_en <= 1'b0;
         por    <= POR_N;
      end else begin
         tck_d  <= next_tck_d;
         st     <= next_st;
         ir_sh  <= next_ir_sh;
         ir     <= next_ir;
         chain  <= next_chain;
         cells  <= next_cells;
         idr    <= next_idr;
         pass   <= next_pass;
         tdo_r  <= next_tdo_r;
         tdo_en <= next_tdo_en;
         por    <= next_por;
      end
   end

   // pin side: cells or core values, drivers float on request
   assign tdo_o      = tdo_r;
   assign tdo_oe_o   = tdo_en;
   assign pin_out_o  = drive_cells ? cells[NB-1:N_IN] : core_out_i; // see R1 R6
   assign pin_oe_o   = ~floating;                                   // see R5
   assign core_ins_o = core_in_i;
endmodule

/* verification/bsid_checker.sv */
// bsid_checker.sv: port assertions for the test-access block
// assumes the ports of bsid_top; bound to it below
`timescale 1ns/1ps
module bsid_checker #(
   parameter int N_IN  = 8, // functional inputs
   parameter int N_OUT = 8  // functional outputs
) (
   input wire logic             clock_i,    // block clock
   input wire logic             rst_i,      // async reset, high
   input wire logic             tck_i,      // test clock pin
   input wire logic             trst_n_i,   // test reset, low
   input wire logic [N_IN-1:0]  core_in_i,  // input pins
   input wire logic [N_OUT-1:0] core_out_i, // core outputs
   input wire logic             tdo_o,      // test data out
   input wire logic             tdo_oe_o,   // its enable
   input wire logic [N_OUT-1:0] pin_out_o,  // output pins
   input wire logic             pin_oe_o,   // output enable
   input wire logic [N_IN-1:0]  core_ins_o  // inputs to core
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // test clock fall or rise seen through the synchroniser a few clocks back
   sequence s_fall_seen;
      !$past(tck_i, 2) && $past(tck_i, 6);
   endsequence
   sequence s_rise_seen;
      $past(tck_i, 2) && !$past(tck_i, 7);
   endsequence
   a_tdo_on_fall: assert property (trst_n_i && ($changed(tdo_oe_o)
      || ($changed(tdo_o) && tdo_oe_o)) |-> s_fall_seen)
      else $error("test data out moved without a clock fall");
   a_tdo_stands: assert property ($rose(tck_i)
      |-> ##3 ($stable(tdo_o) && $stable(tdo_oe_o))[*4]) else $error("test data out moved early");
   a_oe_window: assert property ($rose(tdo_oe_o) |=> tdo_oe_o[*6])
      else $error("test data out enable too short");
   a_oe_on_rise: assert property (($changed(pin_oe_o) && trst_n_i && $past(trst_n_i, 4))
      |-> s_rise_seen) else $error("output enable moved without a clock rise");
   a_pins_on_rise: assert property (($changed(pin_out_o) && $stable(core_out_i) && trst_n_i
      && $past(trst_n_i, 4)) |-> s_rise_seen) else $error("pins moved without a clock rise");
   a_ins_pass: assert property (core_ins_o == core_in_i)
      else $error("core inputs differ from pins");
   a_por_quiet: assert property ($fell(rst_i) |-> (pin_oe_o && !tdo_oe_o)[*8])
      else $error("outputs active during power-up reset");
   a_trst_reset: assert property ($fell(trst_n_i) |-> ##[1:5] (pin_oe_o && !tdo_oe_o))
      else $error("test reset not applied");
endmodule
bind bsid_top bsid_checker #(.N_IN(N_IN), .N_OUT(N_OUT)) u_chk (.clock_i(clock_i),
   .rst_i(rst_i), .tck_i(tck_i), .trst_n_i(trst_n_i), .core_in_i(core_in_i),
   .core_out_i(core_out_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .pin_out_o(pin_out_o),
   .pin_oe_o(pin_oe_o), .core_ins_o(core_ins_o));

/* verification/bsid_ctl_model.sv */
// bsid_ctl_model.sv: external test controller driving the test port
// assumes the test clock stands low between scans
`timescale 1ns/1ps
module bsid_ctl_model (
   input  wire logic clock_i, // block clock, used for phase only
   input  wire logic tdo_i,   // test data out from device
   output logic      tck_o,   // test clock, 200 ns period
   output logic      tms_o,   // mode select
   output logic      tdi_o    // test data in
);
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end
   // one test clock: levels held over the rise, data out taken late in high half
   task automatic step(input logic ms, input logic di, output logic q);
      tms_o = ms;
      tdi_o = di;
      #100 tck_o = 1'b1;
      #90 q = tdo_i;
      #10 tck_o = 1'b0;
   endtask
   // five clocks with mode select high reach reset from any state, one low enters idle
   task automatic to_idle();
      logic q;
      @(posedge clock_i);
      #2;
      repeat (5) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask
   // idle to shift, n bits lsb first, update, back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic q;
      dout = '0;
      @(posedge clock_i);
      #2;
      step(1'b1, 1'b0, q);
      if (ir) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
      step(1'b0, 1'b0, q);
      for (int k = 0; k < n; k++) begin
         step(k == n - 1, din[k], q);
         dout[k] = q;
      end
      step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask
endmodule

/* verification/tb.sv */
// tb.sv: self-checking bench for the test-access block
// assumes bsid_defs.svh on the include path and the controller model
`timescale 1ns/1ps
`include "bsid_defs.svh"
module tb;
   import bsid_pkg::*;
   localparam logic [3:0]  REV  = 4'h6;    // arbitrary value
   localparam logic [15:0] PART = 16'h4a5c; // arbitrary value
   localparam logic [10:0] VEND = 11'h2b1; // arbitrary value
   logic        clock_i = 1'b0, rst_i = 1'b1, trst_n = 1'b1;
   logic        tck, tms, tdi, tdo, tdo_oe, pin_oe, tdo_line;
   logic [7:0]  core_in = 8'ha5, core_out = 8'h3c, pin_out, core_ins;
   logic [31:0] d;
   int          n_errors = 0, cmp_count = 0;
   always #12.5 clock_i = ~clock_i;
   bsid_top #(.REV_ID(REV), .PART_ID(PART), .VEND_ID(VEND)) i_dut (.clock_i(clock_i),
      .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n),
      .core_in_i(core_in), .core_out_i(core_out), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
      .pin_out_o(pin_out), .pin_oe_o(pin_oe), .core_ins_o(core_ins));
   // a released data out shows the inverse of its last value
   assign tdo_line = tdo_oe ? tdo : ~tdo;
   bsid_ctl_model i_ctl (.clock_i(clock_i), .tdo_i(tdo_line), .tck_o(tck), .tms_o(tms),
      .tdi_o(tdi));
   // count a comparison and report a mismatch
   task automatic chk(input logic ok, input string what);
      cmp_count++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask
   // load an instruction; the captured code comes out first
   task automatic load(input logic [3:0] code);
      i_ctl.scan(1'b1, 4, {28'h0, code}, d);
      chk(d[3:0] === `BSID_OP_CAPTURE, "captured instruction");
   endtask
   // single-bit path: captured 0 then the bit shifted in
   task automatic pass_path();
      i_ctl.scan(1'b0, 2, 32'h1, d);
      chk(d[1:0] === 2'b10, "path not single bit");
      chk(tdo_oe === 1'b0, "data out driven in idle");
   endtask
   task automatic t_reset();
      chk(pin_oe === 1'b1 && tdo_oe === 1'b0, "reset outputs");
      chk(pin_out === core_out, "reset pins");
      i_ctl.to_idle();
      pass_path();
      $display("test reset done");
   endtask
   task automatic t_ident();
      load(`BSID_OP_IDLOAD);
      i_ctl.scan(1'b0, 32, 32'h0, d);
      chk(d === {REV, PART, VEND, 1'b1}, "identification word");
      $display("test ident done");
   endtask
   task automatic t_sample();
      load(`BSID_OP_SAMPLE);
      i_ctl.scan(1'b0, 16, 32'hc3e1, d);
      chk(d[15:0] === {core_out, core_in}, "sampled pins");
      chk(pin_out === core_out && pin_oe === 1'b1, "pins under sample");
      chk(core_ins === core_in, "core inputs");
      load(`BSID_OP_EXTEST);
      chk(pin_out === 8'hc3 && pin_oe === 1'b1, "preloaded pins");
      i_ctl.scan(1'b0, 16, 32'h5a00, d);
      chk(pin_out === 8'h5a, "cells drive pins");
      $display("test sample done");
   endtask
   task automatic t_modes();
      load(`BSID_OP_CLAMP);
      chk(pin_out === 8'h5a && pin_oe === 1'b1, "clamp pins");
      pass_path();
      load(`BSID_OP_FLOAT);
      chk(pin_oe === 1'b0, "outputs not floated");
      pass_path();
      @(posedge clock_i);
      #2 trst_n = 1'b0;
      repeat (10) @(posedge clock_i);
      chk(pin_oe === 1'b1 && pin_out === core_out, "test reset");
      #2 trst_n = 1'b1;
      i_ctl.to_idle();
      pass_path();
      load(`BSID_OP_BYPASS);
      chk(pin_out === core_out && pin_oe === 1'b1, "bypass pins");
      pass_path();
      $display("test modes done");
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // watchdog: the tests need well under 100 us
   initial begin
      #400000;
      n_errors++;
      $display("unexpected at %0t: watchdog", $time);
      summarize();
   end
   initial begin
      repeat (10) @(posedge clock_i);
      #2 rst_i = 1'b0;
      repeat (12) @(posedge clock_i);
      t_reset();
      t_ident();
      t_sample();
      t_modes();
      summarize();
   end
endmodule
